// ---- logic/psd_access.sv ----
// Overview of operation
// - table low read, word form, returns program bits 15:0 as data
// - table low read, byte form: byte select 1 upper, 0 lower, into bits 7:0
// - table high read, word form: program bits 23:16 low, upper byte zero
// - table high read, byte form: select 0 gives bits 23:16, select 1 zero
// - table operations page from table page register; bit 7 picks configuration space
// - addresses step by two per program word; low and high spaces side by side
// - window redirect only when address bit 15 set and enable bit 2 set
// - visibility page supplies upper bits, address bits 14:0 the lower bits
// - window covers data addresses 8000h upward, mapped into the selected page
// - window returns only low sixteen bits of the program word
// - window read stretches the instruction by one or two extra cycles, none in middle repeat iterations
// - window redirect suspended while a table write runs (tbl_wr_busy_i)
// - outside repeat: move ops one extra cycle, others two
// - in repeat: first, last, interrupt exit and re-entry take two extra
// - other repeat iterations complete window reads in a single cycle
// - self-programming writes row or word, erases 512-word pages
// - table address is table page above the 16-bit effective address
// - window: address bit 15 ignored, program bit 15 from page bit 0, bit 23 zero
`timescale 1ns/100ps
module psd_access #(
  parameter int unsigned AW = 12
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // core access port
  input  wire logic                      acc_valid_i,
  input  wire psd_pkg::psd_kind_t        acc_kind_i,
  input  wire logic [15:0]               acc_effective_address_i,
  input  wire logic                      acc_byte_i,
  input  wire logic                      acc_move_i,
  input  wire logic                      acc_rpt_i,
  input  wire logic                      acc_rpt_mid_i,
  output logic                           acc_ready_o,
  output logic                           acc_done_o,
  output logic      [15:0]               acc_rdata_o,
  output logic                           acc_ds_route_o,
  output logic                           acc_window_o,
  // flash programming unit
  input  wire logic                      tbl_wr_busy_i,
  input  wire logic                      pm_wr_i,
  input  wire logic [AW:0]               pm_wr_idx_i,
  input  wire logic [23:0]               pm_wr_data_i,
  input  wire logic                      erase_req_i,
  input  wire logic [AW-psd_pkg::PAGE_BITS:0] erase_page_i,
  output logic                           erase_busy_o
);

  localparam int unsigned IW = AW + 1;

  if (AW < psd_pkg::PAGE_BITS || AW > 22) begin : g_aw_check
    $error("psd_access: AW out of range");
  end

  // ****************************************
  // decode functions
  // ****************************************
  function automatic logic [23:0] table_addr(input logic [7:0] page, input logic [15:0] eff_addr);
    table_addr = {page, eff_addr};
  endfunction : table_addr

  function automatic logic [23:0] window_addr(input logic [7:0] page, input logic [15:0] eff_addr);
    window_addr = {1'b0, page, eff_addr[14:0]};
  endfunction : window_addr

  // word index drops bit 0: addresses step by two per program word
  function automatic logic [IW-1:0] word_index(input logic [23:0] pa);
    word_index = {pa[psd_pkg::CFG_SPACE_BIT + 16], pa[AW:1]};
  endfunction : word_index

  function automatic logic [15:0] format_read(input psd_pkg::psd_kind_t kind, input logic byte_mode,
                                              input logic bsel, input logic [23:0] w);
    format_read = 16'h0000;
    unique case (kind)
      psd_pkg::PSD_KIND_TBL_LO: begin
        if (!byte_mode) begin
          format_read = w[15:0];
        end else begin
          format_read = {8'h00, bsel ? w[15:8] : w[7:0]};
        end
      end
      psd_pkg::PSD_KIND_TBL_HI: begin
        if (!byte_mode) begin
          format_read = {8'h00, w[23:16]};
        end else begin
          format_read = {8'h00, bsel ? 8'h00 : w[23:16]};
        end
      end
      psd_pkg::PSD_KIND_DATA: begin
        format_read = w[15:0];
      end
      default: begin
        format_read = 16'h0000;
      end
    endcase
  endfunction : format_read

  // ****************************************
  // registers
  // ****************************************
  typedef enum logic [1:0] {
    PSD_IDLE,
    PSD_FETCH,
    PSD_EXTRA,
    PSD_DONE
  } psd_state_t;

  psd_state_t         state_ff;
  logic [7:0]         table_page_ff;
  logic [7:0]         vis_page_ff;
  logic               win_en_ff;
  logic               wb_ack_ff;
  logic [31:0]        wb_dat_ff;
  logic [1:0]         extra_ff;
  logic               win_ff;
  logic               ds_hit_ff;
  psd_pkg::psd_kind_t kind_ff;
  logic               byte_ff;
  logic               bsel_ff;
  logic [15:0]        rdata_ff;
  logic [23:0]        word_ff;
  logic               erasing_ff;
  logic [8:0]         erase_cnt_ff;
  logic [AW-psd_pkg::PAGE_BITS:0] erase_page_ff;

  logic               take;
  logic               is_win;
  logic [1:0]         nxt_extra;
  logic [23:0]        pa;
  logic [23:0]        mem_rdata;
  logic               mem_we;
  logic [IW-1:0]      mem_waddr;
  logic [23:0]        mem_wdata;
  logic               wb_req;

  // ****************************************
  // wishbone slave
  // ****************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
    end else begin
      wb_ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      table_page_ff <= psd_pkg::TABLE_PAGE_RST;
      vis_page_ff   <= psd_pkg::VIS_PAGE_RST;
      win_en_ff     <= psd_pkg::WIN_EN_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        psd_pkg::OFF_TABLE_PAGE: table_page_ff <= wb_dat_i[7:0];
        psd_pkg::OFF_VIS_PAGE:   vis_page_ff   <= wb_dat_i[7:0];
        psd_pkg::OFF_CORE_CTRL:  win_en_ff     <= wb_dat_i[psd_pkg::WIN_EN_BIT];
        default: begin
        end
      endcase
    end
  end

  // unmapped reads answer zero, unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_ff <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_ff <= 32'h00000000;
      unique case (wb_adr_i)
        psd_pkg::OFF_TABLE_PAGE: wb_dat_ff[7:0] <= table_page_ff;
        psd_pkg::OFF_VIS_PAGE:   wb_dat_ff[7:0] <= vis_page_ff;
        psd_pkg::OFF_CORE_CTRL:  wb_dat_ff[psd_pkg::WIN_EN_BIT] <= win_en_ff;
        psd_pkg::OFF_STATUS: begin
          wb_dat_ff[psd_pkg::ST_BUSY_BIT]  <= (state_ff != PSD_IDLE);
          wb_dat_ff[psd_pkg::ST_WIN_BIT]   <= win_ff;
          wb_dat_ff[psd_pkg::ST_ERASE_BIT] <= erasing_ff;
        end
        default: begin
        end
      endcase
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;

  // ****************************************
  // access decode
  // ****************************************
  // erase owns the array, so new accesses wait until it ends
  assign acc_ready_o = (state_ff == PSD_IDLE) && !erasing_ff && !erase_req_i;
  assign take        = acc_valid_i && acc_ready_o;

  assign is_win = (acc_kind_i == psd_pkg::PSD_KIND_DATA) && acc_effective_address_i[psd_pkg::EFF_ADDR_MSB]
                  && win_en_ff && !tbl_wr_busy_i;

  assign pa = is_win ? window_addr(vis_page_ff, acc_effective_address_i)
                     : table_addr(table_page_ff, acc_effective_address_i);

  // second program fetch is what costs the extra cycles
  always_comb begin
    if (acc_rpt_mid_i) begin
      nxt_extra = psd_pkg::EXTRA_RPT_MID;
    end else if (acc_rpt_i) begin
      nxt_extra = psd_pkg::EXTRA_OTHER;
    end else if (acc_move_i) begin
      nxt_extra = psd_pkg::EXTRA_MOVE;
    end else begin
      nxt_extra = psd_pkg::EXTRA_OTHER;
    end
  end

  // ****************************************
  // access sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= PSD_IDLE;
    end else begin
      unique case (state_ff)
        PSD_IDLE:  if (take) state_ff <= PSD_FETCH;
        PSD_FETCH: state_ff <= (extra_ff != 2'h0) ? PSD_EXTRA : PSD_DONE;
        PSD_EXTRA: if (extra_ff == 2'h1) state_ff <= PSD_DONE;
        PSD_DONE:  state_ff <= PSD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      extra_ff <= 2'h0;
    end else if (take) begin
      extra_ff <= is_win ? nxt_extra : 2'h0;
    end else if (state_ff == PSD_EXTRA) begin
      extra_ff <= extra_ff - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_ff    <= 1'b0;
      ds_hit_ff <= 1'b0;
      kind_ff   <= psd_pkg::PSD_KIND_DATA;
      byte_ff   <= 1'b0;
      bsel_ff   <= 1'b0;
    end else if (take) begin
      win_ff    <= is_win;
      ds_hit_ff <= (acc_kind_i == psd_pkg::PSD_KIND_DATA) && !is_win;
      kind_ff   <= acc_kind_i;
      byte_ff   <= acc_byte_i && (acc_kind_i != psd_pkg::PSD_KIND_DATA);
      bsel_ff   <= acc_effective_address_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 16'h0000;
      word_ff  <= 24'h000000;
    end else if (state_ff == PSD_FETCH) begin
      word_ff  <= mem_rdata;
      rdata_ff <= ds_hit_ff ? 16'h0000 : format_read(kind_ff, byte_ff, bsel_ff, mem_rdata);
    end
  end

  assign acc_done_o     = (state_ff == PSD_DONE);
  assign acc_rdata_o    = rdata_ff;
  assign acc_ds_route_o = ds_hit_ff;
  assign acc_window_o   = win_ff;

  // ****************************************
  // programming path
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erasing_ff    <= 1'b0;
      erase_cnt_ff  <= 9'h000;
      erase_page_ff <= '0;
    end else if (!erasing_ff && erase_req_i && state_ff == PSD_IDLE) begin
      erasing_ff    <= 1'b1;
      erase_cnt_ff  <= 9'h000;
      erase_page_ff <= erase_page_i;
    end else if (erasing_ff) begin
      erase_cnt_ff <= erase_cnt_ff + 9'h001;
      if (erase_cnt_ff == 9'(psd_pkg::PAGE_WORDS - 1)) begin
        erasing_ff <= 1'b0;
      end
    end
  end

  // word writes come one at a time; a row is 64 of them in order
  assign mem_we    = erasing_ff || pm_wr_i;
  assign mem_waddr = erasing_ff ? {erase_page_ff, erase_cnt_ff} : pm_wr_idx_i;
  assign mem_wdata = erasing_ff ? psd_pkg::ERASED_WORD : pm_wr_data_i;

  assign erase_busy_o = erasing_ff;

  psd_pm_mem #(
    .IW    (IW),
    .WIDTH (psd_pkg::PROG_WIDTH)
  ) u_mem (
    .clk_i   (clk_i),
    .re_i    (take && (acc_kind_i != psd_pkg::PSD_KIND_DATA || is_win)),
    .raddr_i (word_index(pa)),
    .rdata_o (mem_rdata),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata)
  );

  // ****************************************
  // checks
  // ****************************************
  tbl_low_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_done_o && kind_ff == psd_pkg::PSD_KIND_TBL_LO && !byte_ff |-> acc_rdata_o == word_ff[15:0])
    else $error("table low word read wrong");

  tbl_low_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_done_o && kind_ff == psd_pkg::PSD_KIND_TBL_LO && byte_ff
    |-> acc_rdata_o == {8'h00, bsel_ff ? word_ff[15:8] : word_ff[7:0]})
    else $error("table low byte read wrong");

  tbl_high_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_done_o && kind_ff == psd_pkg::PSD_KIND_TBL_HI && !byte_ff
    |-> acc_rdata_o == {8'h00, word_ff[23:16]})
    else $error("table high word read wrong");

  tbl_phantom_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_done_o && kind_ff == psd_pkg::PSD_KIND_TBL_HI && byte_ff && bsel_ff |-> acc_rdata_o == 16'h0000)
    else $error("phantom byte not zero");

  win_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && acc_kind_i == psd_pkg::PSD_KIND_DATA && acc_effective_address_i[psd_pkg::EFF_ADDR_MSB] && !win_en_ff
    |=> acc_ds_route_o && !acc_window_o)
    else $error("disabled window still redirected");

  win_table_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && tbl_wr_busy_i |=> !acc_window_o)
    else $error("window active during table write");

  win_move_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_win && !acc_rpt_i && !acc_rpt_mid_i && acc_move_i
    |=> !acc_done_o [*2] ##1 acc_done_o)
    else $error("move through window not one extra cycle");

  win_rpt_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_win && acc_rpt_i && !acc_rpt_mid_i |=> !acc_done_o [*3] ##1 acc_done_o)
    else $error("repeat edge iteration not two extra cycles");

  win_rpt_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_win && acc_rpt_mid_i |=> !acc_done_o ##1 acc_done_o)
    else $error("repeat middle iteration stalled");

  win_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_win |-> pa[23] == 1'b0 && pa[15] == vis_page_ff[0] && pa[14:0] == acc_effective_address_i[14:0])
    else $error("window address formed wrongly");

endmodule : psd_access

// ---- logic/psd_pkg.sv ----
package psd_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned PROG_WIDTH  = 24;
  localparam int unsigned DATA_WIDTH  = 16;
  localparam int unsigned EFF_ADDR_WIDTH = 16;
  localparam int unsigned PAGE_WIDTH  = 8;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_TABLE_PAGE = 8'h00;
  localparam logic [7:0] OFF_VIS_PAGE   = 8'h04;
  localparam logic [7:0] OFF_CORE_CTRL  = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned WIN_EN_BIT     = 2;
  localparam int unsigned CFG_SPACE_BIT  = 7;
  localparam int unsigned EFF_ADDR_MSB   = 15;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_WIN_BIT     = 1;
  localparam int unsigned ST_ERASE_BIT   = 2;
  localparam logic [7:0]  TABLE_PAGE_RST = 8'h00;
  localparam logic [7:0]  VIS_PAGE_RST   = 8'h00;
  localparam logic        WIN_EN_RST     = 1'b0;

  // ****************************************
  // timing counts and flash geometry
  // ****************************************
  localparam logic [1:0]  EXTRA_MOVE      = 2'h1;
  localparam logic [1:0]  EXTRA_OTHER     = 2'h2;
  localparam logic [1:0]  EXTRA_RPT_MID   = 2'h0;
  localparam int unsigned ROW_WORDS       = 64;
  localparam int unsigned PAGE_WORDS      = 512;
  localparam int unsigned PAGE_BITS       = 9;
  localparam logic [23:0] ERASED_WORD     = 24'hFFFFFF;

  typedef enum logic [1:0] {
    PSD_KIND_DATA,
    PSD_KIND_TBL_LO,
    PSD_KIND_TBL_HI
  } psd_kind_t;

endpackage : psd_pkg

// ---- logic/psd_pm_mem.sv ----
`timescale 1ns/100ps
module psd_pm_mem #(
  parameter int unsigned IW    = 13,
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clk_i,
  input  wire logic             re_i,
  input  wire logic [IW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o,
  input  wire logic             we_i,
  input  wire logic [IW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i
);

  // ****************************************
  // storage, registered read
  // ****************************************
  logic [WIDTH-1:0] mem_ff [2**IW];
  logic [WIDTH-1:0] rdata_ff;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (re_i) begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule : psd_pm_mem

// ---- testbench/psd_core_model.sv ----
`timescale 1ns/100ps
// ****************************************
// processor core side: one access at a time
// ****************************************
module psd_core_model (
  input  wire logic          clk_i,
  input  wire logic          acc_ready_i,
  input  wire logic          acc_done_i,
  input  wire logic [15:0]   acc_rdata_i,
  output logic               acc_valid_o,
  output psd_pkg::psd_kind_t acc_kind_o,
  output logic      [15:0]   acc_effective_address_o,
  output logic               acc_byte_o,
  output logic               acc_move_o,
  output logic               acc_rpt_o,
  output logic               acc_rpt_mid_o
);
  initial begin
    acc_valid_o   = 1'b0;
    acc_kind_o    = psd_pkg::PSD_KIND_DATA;
    acc_effective_address_o = 16'h0000;
    acc_byte_o    = 1'b0;
    acc_move_o    = 1'b0;
    acc_rpt_o     = 1'b0;
    acc_rpt_mid_o = 1'b0;
  end

  // fl is {byte, move, repeat edge, repeat middle}; lat counts edges from take to done
  task automatic issue(input psd_pkg::psd_kind_t k, input logic [15:0] addr, input logic [3:0] fl,
                       output int lat, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_kind_o  <= k;
    acc_effective_address_o <= addr;
    {acc_byte_o, acc_move_o, acc_rpt_o, acc_rpt_mid_o} <= fl;
    // waits out an erase too, hence the long bound
    do begin @(posedge clk_i); n++; end while (acc_ready_i !== 1'b1 && n < 600);
    acc_valid_o <= 1'b0;
    // released address shows its inverse, never a stale copy
    acc_effective_address_o <= ~addr;
    n = 0;
    do begin @(posedge clk_i); n++; end while (acc_done_i !== 1'b1 && n < 20);
    lat = n;
    rd  = acc_rdata_i;
  endtask : issue
endmodule : psd_core_model

// ---- testbench/tb_program_space_data_access.sv ----
`timescale 1ns/100ps
module tb_program_space_data_access;
  localparam int AW = 16;
  logic               clk_i       = 1'b0;
  logic               rst_i       = 1'b1;
  logic               wb_cyc      = 1'b0;
  logic               wb_stb      = 1'b0;
  logic               wb_we       = 1'b0;
  logic [7:0]         wb_adr      = 8'h00;
  logic [31:0]        wb_wdat     = 32'h0;
  logic [31:0]        wb_rdat;
  logic               wb_ack;
  logic               acc_valid, acc_byte, acc_move, acc_rpt, acc_mid;
  psd_pkg::psd_kind_t acc_kind;
  logic [15:0]        acc_addr, acc_rdata;
  logic               acc_ready, acc_done, acc_route, acc_window, erase_busy;
  logic               tbl_wr_busy = 1'b0;
  logic               pm_wr       = 1'b0;
  logic [AW:0]        pm_idx      = '0;
  logic [23:0]        pm_data     = 24'h0;
  logic               erase_req   = 1'b0;
  logic [AW-9:0]      erase_page  = '0;
  int                 n_fail      = 0;
  int                 tests_run   = 0;

  always #2 clk_i = ~clk_i;

  psd_access #(.AW(AW)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .acc_valid_i(acc_valid), .acc_kind_i(acc_kind), .acc_effective_address_i(acc_addr),
    .acc_byte_i(acc_byte), .acc_move_i(acc_move), .acc_rpt_i(acc_rpt), .acc_rpt_mid_i(acc_mid),
    .acc_ready_o(acc_ready), .acc_done_o(acc_done), .acc_rdata_o(acc_rdata), .acc_ds_route_o(acc_route),
    .acc_window_o(acc_window), .tbl_wr_busy_i(tbl_wr_busy), .pm_wr_i(pm_wr), .pm_wr_idx_i(pm_idx),
    .pm_wr_data_i(pm_data), .erase_req_i(erase_req), .erase_page_i(erase_page), .erase_busy_o(erase_busy));

  psd_core_model u_core (.clk_i(clk_i), .acc_ready_i(acc_ready), .acc_done_i(acc_done),
    .acc_rdata_i(acc_rdata), .acc_valid_o(acc_valid), .acc_kind_o(acc_kind), .acc_effective_address_o(acc_addr),
    .acc_byte_o(acc_byte), .acc_move_o(acc_move), .acc_rpt_o(acc_rpt), .acc_rpt_mid_o(acc_mid));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    do begin @(posedge clk_i); n++; end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk("bus ack", 32'h1, {31'h0, wb_ack});
  endtask : wb

  // program address a is {page, ea}; the store index is {space bit, a[AW:1]}
  task automatic pm_put(input logic [23:0] a, input logic [23:0] w);
    @(posedge clk_i);
    pm_wr   <= 1'b1;
    pm_idx  <= {a[23], a[AW:1]};
    pm_data <= w;
    @(posedge clk_i);
    pm_wr   <= 1'b0;
  endtask : pm_put

  task automatic op(input psd_pkg::psd_kind_t k, input logic [15:0] addr, input logic [3:0] fl,
                    input int lat, input logic [15:0] exp, input logic [15:0] msk);
    int n;
    logic [15:0] rd;
    u_core.issue(k, addr, fl, n, rd);
    chk("latency", lat, n);
    chk("read data", {16'h0, exp & msk}, {16'h0, rd & msk});
  endtask : op

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [7:0]  offs [5];
    int          n;
    offs = '{psd_pkg::OFF_TABLE_PAGE, psd_pkg::OFF_VIS_PAGE, psd_pkg::OFF_CORE_CTRL, psd_pkg::OFF_STATUS, 8'h10};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h10, 32'hFF, q);
    foreach (offs[i]) begin
      wb(1'b0, offs[i], 32'h0, q);
      chk("reset or unmapped value", 32'h0, q);
    end
    $display("test registers done");

    wb(1'b1, psd_pkg::OFF_TABLE_PAGE, 32'h01, q);
    pm_put(24'h011234, 24'hA5C35A);
    pm_put(24'h001234, 24'h3C3C3C);
    pm_put(24'h011236, 24'h0B0B0B);
    pm_put(24'h811234, 24'h00BEEF);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1234, 4'h0, 2, 16'hC35A, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1236, 4'h0, 2, 16'h0B0B, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1234, 4'h8, 2, 16'h005A, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1235, 4'h8, 2, 16'h00C3, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_HI, 16'h1234, 4'h0, 2, 16'h00A5, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_HI, 16'h1234, 4'h8, 2, 16'h00A5, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_HI, 16'h1235, 4'h8, 2, 16'h0000, 16'hFFFF);
    wb(1'b1, psd_pkg::OFF_TABLE_PAGE, 32'h81, q);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1234, 4'h0, 2, 16'hBEEF, 16'hFFFF);
    wb(1'b1, psd_pkg::OFF_TABLE_PAGE, 32'h00, q);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1234, 4'h0, 2, 16'h3C3C, 16'hFFFF);
    $display("test table reads done");

    // window constants keep their top byte all ones or all zeros
    pm_put({1'b0, 8'h03, 15'h0246}, 24'hFF1357);
    pm_put({1'b0, 8'h02, 15'h0246}, 24'h00AAAA);
    pm_put({1'b0, 8'h03, 15'h7FFE}, 24'hFFABCD);
    wb(1'b1, psd_pkg::OFF_VIS_PAGE, 32'h03, q);
    wb(1'b1, psd_pkg::OFF_CORE_CTRL, 32'h04, q);
    wb(1'b0, psd_pkg::OFF_VIS_PAGE, 32'h0, q);
    chk("visibility page", 32'h03, q);
    wb(1'b0, psd_pkg::OFF_CORE_CTRL, 32'h0, q);
    chk("core control", 32'h1 << psd_pkg::WIN_EN_BIT, q);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h4, 3, 16'h1357, 16'hFFFF);
    chk("window flag", 32'h1, {31'h0, acc_window});
    wb(1'b0, psd_pkg::OFF_STATUS, 32'h0, q);
    chk("status last window", 32'h1 << psd_pkg::ST_WIN_BIT, q);
    op(psd_pkg::PSD_KIND_DATA, 16'hFFFE, 4'h0, 4, 16'hABCD, 16'hFFFF);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h6, 4, 16'h1357, 16'hFFFF);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h2, 4, 16'h1357, 16'hFFFF);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h1, 2, 16'h1357, 16'hFFFF);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h3, 2, 16'h1357, 16'hFFFF);
    wb(1'b1, psd_pkg::OFF_VIS_PAGE, 32'h02, q);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h4, 3, 16'hAAAA, 16'hFFFF);
    $display("test window reads done");

    op(psd_pkg::PSD_KIND_DATA, 16'h7FFE, 4'h4, 2, 16'h0000, 16'hFFFF);
    chk("data route", 32'h1, {31'h0, acc_route});
    tbl_wr_busy <= 1'b1;
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h4, 2, 16'h0000, 16'hFFFF);
    chk("data route", 32'h1, {31'h0, acc_route});
    tbl_wr_busy <= 1'b0;
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h4, 3, 16'hAAAA, 16'hFFFF);
    wb(1'b1, psd_pkg::OFF_CORE_CTRL, 32'h00, q);
    op(psd_pkg::PSD_KIND_DATA, 16'h8246, 4'h4, 2, 16'h0000, 16'hFFFF);
    chk("window flag", 32'h0, {31'h0, acc_window});
    $display("test data routing done");

    // erase the page that holds user words 011234 and 011236
    @(posedge clk_i);
    erase_req  <= 1'b1;
    // store index is {space, addr[16:1]}, so word 011234 sits in page 44
    erase_page <= 8'h44;
    @(posedge clk_i);
    erase_req  <= 1'b0;
    @(posedge clk_i);
    chk("erase busy", 32'h1, {31'h0, erase_busy});
    chk("ready in erase", 32'h0, {31'h0, acc_ready});
    wb(1'b0, psd_pkg::OFF_STATUS, 32'h0, q);
    chk("status in erase", 32'h1 << psd_pkg::ST_ERASE_BIT, q);
    n = 0;
    while (erase_busy === 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk("erase span", 32'h1, {31'h0, n >= 505 && n <= 512});
    wb(1'b1, psd_pkg::OFF_TABLE_PAGE, 32'h01, q);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1234, 4'h0, 2, 16'hFFFF, 16'hFFFF);
    op(psd_pkg::PSD_KIND_TBL_HI, 16'h1236, 4'h0, 2, 16'h00FF, 16'hFFFF);
    wb(1'b1, psd_pkg::OFF_TABLE_PAGE, 32'h81, q);
    op(psd_pkg::PSD_KIND_TBL_LO, 16'h1234, 4'h0, 2, 16'hBEEF, 16'hFFFF);
    $display("test erase done");
    end_of_test();
  end

  // a full run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    end_of_test();
  end
endmodule : tb_program_space_data_access
